// File: hdl/fsc_pkg.sv
// Package of constants and types for the FP status/control register bank
package fsc_pkg;
   // Register byte offsets on APB
   localparam logic [7:0] FSC_OFS_STATUS_CONTROL = 8'h00;
   localparam logic [7:0] FSC_OFS_TRANSFER       = 8'h04;
   localparam logic [7:0] FSC_OFS_EVENT_STATUS   = 8'h08;
   localparam logic [7:0] FSC_OFS_EVENT_MASK     = 8'h0C;
   // Field positions
   localparam int FSC_BIT_BANK_SWAP   = 21;
   localparam int FSC_BIT_MOVE_WIDTH  = 20;
   localparam int FSC_BIT_PRECISION   = 19;
   localparam int FSC_BIT_DENORMAL    = 18;
   localparam int FSC_CAUSE_LSB       = 12;
   localparam int FSC_ENABLE_LSB      = 7;
   localparam int FSC_FLAG_LSB        = 2;
   localparam int FSC_ROUND_LSB       = 0;
   // Reset values
   localparam logic       FSC_RST_DENORMAL  = 1'h1;
   localparam logic [1:0] FSC_RST_ROUNDING  = 2'h1;
   localparam logic [1:0] FSC_EVENT_RST     = 2'h0;
   // Rounding encodings
   localparam logic [1:0] FSC_ROUND_NEAREST = 2'h0;
   localparam logic [1:0] FSC_ROUND_ZERO    = 2'h1;
   // Exception vector: [5]=error [4]=invalid [3]=div0 [2]=overflow [1]=underflow [0]=inexact
   typedef logic [5:0] fsc_cause_type;
   typedef logic [4:0] fsc_exc_type;
   // Mode bits presented to the datapath
   typedef struct packed {
      logic       bank_swap_select;
      logic       move_width_select;
      logic       precision_select;
      logic       denormal_to_zero;
      logic [1:0] rounding_select;
   } fsc_mode_type;
   // Event status bits: [1] trap raised, [0] untrapped exception recorded
   typedef logic [1:0] fsc_event_type;
endpackage

// File: hdl/fsc_regs.sv
// FP status/control and FPU-CPU transfer register bank with APB slave
`timescale 1ns/1ps
`default_nettype none
module fsc_regs
(
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   // APB slave
   input  wire logic                 i_psel,
   input  wire logic                 i_penable,
   input  wire logic                 i_pwrite,
   input  wire logic [7:0]           i_paddr,
   input  wire logic [31:0]          i_pwdata,
   output logic      [31:0]          o_prdata,
   output logic                      o_pready,
   output logic                      o_pslverr,
   // Datapath side
   input  wire logic                 i_op_start,
   input  wire logic                 i_exc_valid,
   input  wire fsc_pkg::fsc_cause_type i_exc_cause,
   input  wire logic                 i_xfer_we,
   input  wire logic [31:0]          i_xfer_wdata,
   output logic      [31:0]          o_xfer_data,
   output fsc_pkg::fsc_mode_type     o_mode,
   output logic                      o_fp_trap,
   output logic                      o_irq
);
   logic                 bank_reg, width_reg, prec_reg, dnz_reg;
   logic [1:0]           round_reg;
   fsc_pkg::fsc_cause_type cause_reg;
   fsc_pkg::fsc_exc_type enable_reg, flag_reg;
   logic [31:0]          xfer_reg;
   fsc_pkg::fsc_event_type evt_reg, mask_reg;
   logic                 wr_stb, rd_stb, hit;
   logic [31:0]          sc_word;
   fsc_pkg::fsc_exc_type exc5;
   logic                 trap_now;

   // Address decode, used for reads and writes
   function automatic logic known_addr(input logic [7:0] a);
      known_addr = (a == fsc_pkg::FSC_OFS_STATUS_CONTROL) || (a == fsc_pkg::FSC_OFS_TRANSFER) ||
                   (a == fsc_pkg::FSC_OFS_EVENT_STATUS) || (a == fsc_pkg::FSC_OFS_EVENT_MASK);
   endfunction

   // APB strobes: first cycle of a two-cycle access phase, before ready
   assign hit    = known_addr(i_paddr);
   assign wr_stb = i_psel && i_penable && i_pwrite && !o_pready;
   assign rd_stb = i_psel && i_penable && !i_pwrite && !o_pready;
   assign exc5   = i_exc_cause[4:0];
   assign trap_now = i_exc_valid && |(exc5 & enable_reg);

   // Assembled status/control word, reserved bits zero
   always_comb
   begin
      sc_word = 32'h0000_0000;
      sc_word[fsc_pkg::FSC_BIT_BANK_SWAP]  = bank_reg;
      sc_word[fsc_pkg::FSC_BIT_MOVE_WIDTH] = width_reg;
      sc_word[fsc_pkg::FSC_BIT_PRECISION]  = prec_reg;
      sc_word[fsc_pkg::FSC_BIT_DENORMAL]   = dnz_reg;
      sc_word[fsc_pkg::FSC_CAUSE_LSB +: 6] = cause_reg;
      sc_word[fsc_pkg::FSC_ENABLE_LSB +: 5] = enable_reg;
      sc_word[fsc_pkg::FSC_FLAG_LSB +: 5]  = flag_reg;
      sc_word[fsc_pkg::FSC_ROUND_LSB +: 2] = round_reg;
   end

   // Mode bits and trap enables, software written
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         bank_reg   <= 1'b0;
         width_reg  <= 1'b0;
         prec_reg   <= 1'b0;
         dnz_reg    <= fsc_pkg::FSC_RST_DENORMAL;
         round_reg  <= fsc_pkg::FSC_RST_ROUNDING;
         enable_reg <= '0;
      end
      else if (wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL)
      begin
         bank_reg   <= i_pwdata[fsc_pkg::FSC_BIT_BANK_SWAP];
         width_reg  <= i_pwdata[fsc_pkg::FSC_BIT_MOVE_WIDTH];
         prec_reg   <= i_pwdata[fsc_pkg::FSC_BIT_PRECISION];
         dnz_reg    <= i_pwdata[fsc_pkg::FSC_BIT_DENORMAL];
         round_reg  <= i_pwdata[fsc_pkg::FSC_ROUND_LSB +: 2];
         enable_reg <= i_pwdata[fsc_pkg::FSC_ENABLE_LSB +: 5];
      end
   end

   // Cause field: cleared per operation, exception bits set, set wins
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cause_reg <= '0;
      else if (i_op_start || i_exc_valid)
         cause_reg <= (i_op_start ? 6'h00 : cause_reg) | (i_exc_valid ? i_exc_cause : 6'h00);
      else if (wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL)
         cause_reg <= i_pwdata[fsc_pkg::FSC_CAUSE_LSB +: 6];
   end

   // Sticky flags: software write, exception set wins
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         flag_reg <= '0;
      else
         flag_reg <= ((wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL) ?
                      i_pwdata[fsc_pkg::FSC_FLAG_LSB +: 5] : flag_reg) |
                     (i_exc_valid ? exc5 : 5'h00);
   end

   // Transfer register, no reset on content
   always_ff @(posedge i_ref_clk)
   begin
      if (i_xfer_we)
         xfer_reg <= i_xfer_wdata;
      else if (wr_stb && i_paddr == fsc_pkg::FSC_OFS_TRANSFER)
         xfer_reg <= i_pwdata;
   end

   // Event status W1C, set wins; event mask
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         evt_reg  <= fsc_pkg::FSC_EVENT_RST;
         mask_reg <= fsc_pkg::FSC_EVENT_RST;
      end
      else
      begin
         evt_reg <= (evt_reg & ~((wr_stb && i_paddr == fsc_pkg::FSC_OFS_EVENT_STATUS) ?
                                 i_pwdata[1:0] : 2'h0)) |
                    {trap_now, i_exc_valid && !trap_now};
         if (wr_stb && i_paddr == fsc_pkg::FSC_OFS_EVENT_MASK)
            mask_reg <= i_pwdata[1:0];
      end
   end

   // Outputs from flops: trap pulse, irq level, mode copy
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_fp_trap <= 1'b0;
         o_irq     <= 1'b0;
         o_mode    <= '{1'b0, 1'b0, 1'b0, fsc_pkg::FSC_RST_DENORMAL, fsc_pkg::FSC_RST_ROUNDING};
      end
      else
      begin
         o_fp_trap <= trap_now;
         o_irq     <= |(evt_reg & mask_reg);
         o_mode    <= '{bank_reg, width_reg, prec_reg, dnz_reg, round_reg};
      end
   end

   // Datapath view of transfer register
   always_ff @(posedge i_ref_clk)
      o_xfer_data <= i_xfer_we ? i_xfer_wdata : xfer_reg;

   // APB answer: ready one cycle into access phase
   always_ff @(posedge i_ref_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0000_0000;
      end
      else
      begin
         o_pready  <= i_psel && i_penable && !o_pready;
         o_pslverr <= i_psel && i_penable && !o_pready && !hit;
         if (rd_stb)
         begin
            unique case (i_paddr)
               fsc_pkg::FSC_OFS_STATUS_CONTROL: o_prdata <= sc_word;
               fsc_pkg::FSC_OFS_TRANSFER:       o_prdata <= xfer_reg;
               fsc_pkg::FSC_OFS_EVENT_STATUS:   o_prdata <= {30'h0, evt_reg};
               fsc_pkg::FSC_OFS_EVENT_MASK:     o_prdata <= {30'h0, mask_reg};
               default:                         o_prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Checks
   property p_reserved_zero;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      rd_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=> o_prdata[31:22] == 10'h000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

   property p_cause_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_op_start && !i_exc_valid |=> cause_reg == 6'h00;
   endproperty
   a_cause_clear: assert property (p_cause_clear) else $error("cause not cleared");

   property p_exc_sets;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_exc_valid |=> ((cause_reg & $past(i_exc_cause)) == $past(i_exc_cause)) &&
                      ((flag_reg & $past(exc5)) == $past(exc5));
   endproperty
   a_exc_sets: assert property (p_exc_sets) else $error("exception bits not set");

   property p_flag_sticky;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !(wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL) |=>
         ((flag_reg & $past(flag_reg)) == $past(flag_reg));
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

   property p_trap;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_exc_valid && |(exc5 & enable_reg) |=> o_fp_trap ##1 !o_fp_trap || $past(trap_now);
   endproperty
   a_trap: assert property (p_trap) else $error("trap missing");

   property p_no_trap;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !(i_exc_valid && |(exc5 & enable_reg)) |=> !o_fp_trap;
   endproperty
   a_no_trap: assert property (p_no_trap) else $error("spurious trap");

   property p_mode_out;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      1'b1 |=> o_mode == {$past(bank_reg), $past(width_reg), $past(prec_reg),
                          $past(dnz_reg), $past(round_reg)};
   endproperty
   a_mode_out: assert property (p_mode_out) else $error("mode output stale");

   property p_xfer_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_xfer_we |=> xfer_reg == $past(i_xfer_wdata) &&
                    o_xfer_data == $past(i_xfer_wdata);
   endproperty
   a_xfer_write: assert property (p_xfer_write) else $error("transfer register lost");

   property p_xfer_apb;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_TRANSFER && !i_xfer_we |=>
         xfer_reg == $past(i_pwdata);
   endproperty
   a_xfer_apb: assert property (p_xfer_apb) else $error("transfer write lost");

   property p_bank_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         bank_reg == $past(i_pwdata[fsc_pkg::FSC_BIT_BANK_SWAP]);
   endproperty
   a_bank_write: assert property (p_bank_write) else $error("bank select not written");

   property p_width_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         width_reg == $past(i_pwdata[fsc_pkg::FSC_BIT_MOVE_WIDTH]);
   endproperty
   a_width_write: assert property (p_width_write) else $error("move width not written");

   property p_prec_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         prec_reg == $past(i_pwdata[fsc_pkg::FSC_BIT_PRECISION]);
   endproperty
   a_prec_write: assert property (p_prec_write) else $error("precision not written");

   property p_dnz_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         dnz_reg == $past(i_pwdata[fsc_pkg::FSC_BIT_DENORMAL]);
   endproperty
   a_dnz_write: assert property (p_dnz_write) else $error("denormal mode not written");

   property p_round_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         round_reg == $past(i_pwdata[fsc_pkg::FSC_ROUND_LSB +: 2]);
   endproperty
   a_round_write: assert property (p_round_write) else $error("rounding not written");

   property p_enable_write;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      wr_stb && i_paddr == fsc_pkg::FSC_OFS_STATUS_CONTROL |=>
         enable_reg == $past(i_pwdata[fsc_pkg::FSC_ENABLE_LSB +: 5]);
   endproperty
   a_enable_write: assert property (p_enable_write) else $error("enable not written");

   property p_exc_fields;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      i_exc_valid |=>
         ((sc_word[fsc_pkg::FSC_CAUSE_LSB +: 6] & $past(i_exc_cause)) == $past(i_exc_cause)) &&
         ((sc_word[fsc_pkg::FSC_FLAG_LSB +: 5] & $past(exc5)) == $past(exc5));
   endproperty
   a_exc_fields: assert property (p_exc_fields) else $error("exception bit misplaced");

   property p_event_sticky;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      !(wr_stb && i_paddr == fsc_pkg::FSC_OFS_EVENT_STATUS) |=>
         ((evt_reg & $past(evt_reg)) == $past(evt_reg));
   endproperty
   a_event_sticky: assert property (p_event_sticky) else $error("event bit dropped");

   property p_ready_pulse;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_pready |=> !o_pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

   property p_err_ready;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      o_pslverr |-> o_pready;
   endproperty
   a_err_ready: assert property (p_err_ready) else $error("error without ready");
endmodule // fsc_regs
`default_nettype wire

// File: verification/fsc_cpu_model.sv
// Integer CPU model issuing FP operations, exceptions and transfers
`timescale 1ns/1ps
`default_nettype none
module fsc_cpu_model
(
   input  wire logic              i_ref_clk,
   output logic                   o_op_start,
   output logic                   o_exc_valid,
   output fsc_pkg::fsc_cause_type o_exc_cause,
   output logic                   o_xfer_we,
   output logic [31:0]            o_xfer_wdata
);
   // Idle at time zero
   initial
   begin
      o_op_start   = 1'h0;
      o_exc_valid  = 1'h0;
      o_exc_cause  = 6'h15;
      o_xfer_we    = 1'h0;
      o_xfer_wdata = 32'hDEADBEEF;
   end
   // One instruction for one cycle; payloads turn to junk once released
   task automatic issue(input logic op, input logic ev, input fsc_pkg::fsc_cause_type c,
                        input logic xw, input logic [31:0] d);
      @(posedge i_ref_clk);
      o_op_start   <= op;
      o_exc_valid  <= ev;
      o_exc_cause  <= c;
      o_xfer_we    <= xw;
      o_xfer_wdata <= d;
      @(posedge i_ref_clk);
      o_op_start   <= 1'h0;
      o_exc_valid  <= 1'h0;
      o_exc_cause  <= ~c;
      o_xfer_we    <= 1'h0;
      o_xfer_wdata <= ~d;
   endtask
endmodule // fsc_cpu_model
`default_nettype wire

// File: verification/fsc_regs_tb.sv
// Self-checking bench for the FP status/control register bank
`timescale 1ns/1ps
`default_nettype none
module fsc_regs_tb;
   logic                   ref_clk = 1'h0;
   logic                   rst_n   = 1'h0;
   logic                   psel    = 1'h0;
   logic                   penable = 1'h0;
   logic                   pwrite  = 1'h0;
   logic [7:0]             paddr   = 8'h00;
   logic [31:0]            pwdata  = 32'h00000000;
   logic [31:0]            prdata, xfer_data, rd, wdat;
   logic                   pready, pslverr, fp_trap, irq, er, op, ev, xw;
   fsc_pkg::fsc_cause_type cause;
   fsc_pkg::fsc_mode_type  mode;
   int                     err_count = 0;
   int                     checks = 0;
   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;
   fsc_cpu_model cpu (.i_ref_clk(ref_clk), .o_op_start(op), .o_exc_valid(ev),
                      .o_exc_cause(cause), .o_xfer_we(xw), .o_xfer_wdata(wdat));
   fsc_regs uut (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
                 .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
                 .o_pready(pready), .o_pslverr(pslverr), .i_op_start(op), .i_exc_valid(ev),
                 .i_exc_cause(cause), .i_xfer_we(xw), .i_xfer_wdata(wdat),
                 .o_xfer_data(xfer_data), .o_mode(mode), .o_fp_trap(fp_trap), .o_irq(irq));
   // Verdict and end of run
   task automatic conclude();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // APB transfer; read data and error land in rd and er
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      for (int n = 0; n <= 20; n++)
      begin
         @(posedge ref_clk);
         if (pready === 1'h1)
            break;
         if (n == 20)
         begin
            err_count++;
            conclude();
         end
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   // Read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Count trap pulses over the next few edges
   task automatic trap_count(input int exp);
      int t = 0;
      repeat (4)
      begin
         @(posedge ref_clk);
         t += (fp_trap === 1'h1);
      end
      chk(t, exp);
   endtask
   // Bounded wait for the interrupt level
   task automatic wait_irq(input logic lvl);
      for (int n = 0; n < 8 && irq !== lvl; n++) @(posedge ref_clk);
      chk(irq, lvl);
      if (irq !== lvl)
         conclude();
   endtask
   // Reset values, reserved bits and mode outputs
   task automatic t_ctrl();
      rchk(8'h00, 32'h00040001);
      chk(er, 1'h0);
      chk(mode, 6'h05);
      apb(1'h1, 8'h00, 32'hFFFFFFFF);
      rchk(8'h00, 32'h003FFFFF);
      repeat (2) @(posedge ref_clk);
      chk(mode, 6'h3F);
      apb(1'h1, 8'h00, 32'h00000000);
      rchk(8'h00, 32'h00000000);
      repeat (2) @(posedge ref_clk);
      chk(mode, 6'h00);
      apb(1'h1, 8'h00, 32'h00040001);
   endtask
   // Untrapped exception, cause clearing and sticky flags
   task automatic t_exc();
      cpu.issue(1'h1, 1'h1, 6'h08, 1'h0, 32'h0);
      trap_count(0);
      rchk(8'h00, 32'h00048021);
      cpu.issue(1'h1, 1'h0, 6'h00, 1'h0, 32'h0);
      rchk(8'h00, 32'h00040021);
      apb(1'h1, 8'h00, 32'h00040001);
      rchk(8'h00, 32'h00040001);
   endtask
   // Enabled exception with the error bit, then the interrupt path
   task automatic t_trap();
      apb(1'h1, 8'h00, 32'h00040401);
      cpu.issue(1'h0, 1'h1, 6'h28, 1'h0, 32'h0);
      trap_count(1);
      rchk(8'h00, 32'h00068421);
      rchk(8'h08, 32'h00000003);
      chk(irq, 1'h0);
      apb(1'h1, 8'h0C, 32'h00000002);
      wait_irq(1'h1);
      apb(1'h1, 8'h08, 32'h00000003);
      wait_irq(1'h0);
      rchk(8'h08, 32'h00000000);
   endtask
   // Transfer register both ways and an unmapped address
   task automatic t_xfer();
      cpu.issue(1'h0, 1'h0, 6'h00, 1'h1, 32'hA5A55A5A);
      @(posedge ref_clk);
      chk(xfer_data, 32'hA5A55A5A);
      rchk(8'h04, 32'hA5A55A5A);
      apb(1'h1, 8'h04, 32'h0F0F1234);
      rchk(8'h04, 32'h0F0F1234);
      chk(xfer_data, 32'h0F0F1234);
      apb(1'h1, 8'h10, 32'hFFFFFFFF);
      chk(er, 1'h1);
      rchk(8'h10, 32'h00000000);
      chk(er, 1'h1);
      rchk(8'h00, 32'h00068421);
   endtask
   // Main sequence
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'h1;
      t_ctrl();
      t_exc();
      t_trap();
      t_xfer();
      conclude();
   end
endmodule // fsc_regs_tb
`default_nettype wire
